// ===== hw/rcc_pkg.sv
package rcc_pkg;
  // register port, byte address = index * 4
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_CFG  = 8'h31;
  localparam logic [7:0] IDX_STAT = 8'h38;
  localparam logic [7:0] IDX_MASK = 8'h39;
  localparam logic [7:0] IDX_INFO = 8'h3a;
  localparam logic [9:0] ADDR_CFG  = {IDX_CFG, 2'b00};
  localparam logic [9:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [9:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [9:0] ADDR_INFO = {IDX_INFO, 2'b00};
  // configuration word layout
  localparam int unsigned CFG_VAL_LSB = 16;
  localparam int unsigned CFG_FORCE   = 7;
  localparam int unsigned CFG_PASS    = 6;
  localparam int unsigned CFG_SEL_LSB = 3;
  localparam int unsigned CFG_TYPE    = 2;
  localparam int unsigned CFG_INV     = 1;
  localparam int unsigned CFG_EN      = 0;
  localparam logic [31:0] CFG_WMASK = 32'hffff_00ff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // preset selector codes and values
  typedef enum logic [2:0] {
    SEL_0000 = 3'b000,
    SEL_6363 = 3'b001,
    SEL_A671 = 3'b010,
    SEL_FFFF = 3'b011,
    SEL_0012 = 3'b100,
    SEL_E012 = 3'b101,
    SEL_RFU  = 3'b110,
    SEL_FREE = 3'b111
  } rcc_preset_sel_t;
  localparam logic [15:0] PRESET_0000 = 16'h0000;
  localparam logic [15:0] PRESET_6363 = 16'h6363;
  localparam logic [15:0] PRESET_A671 = 16'ha671;
  localparam logic [15:0] PRESET_FFFF = 16'hffff;
  localparam logic [15:0] PRESET_0012 = 16'h0012;
  localparam logic [15:0] PRESET_E012 = 16'he012;
  localparam logic [15:0] PRESET_RFU  = 16'h0000;
  localparam logic [15:0] PRESET_LSB_MASK = 16'h00ff;
  // crc shapes, lsb first
  localparam logic [15:0] POLY16 = 16'h8408;
  localparam logic [15:0] POLY5  = 16'h0014;
  localparam logic [15:0] MASK16 = 16'hffff;
  localparam logic [15:0] MASK5  = 16'h001f;
  localparam logic [15:0] RESID_PLAIN = 16'h0000;
  localparam logic [15:0] RESID_INV   = 16'hf0b8;
  localparam logic [4:0] LEN16 = 5'd16;
  localparam logic [4:0] LEN5  = 5'd5;
  localparam logic [4:0] HOLD_ONE = 5'd1;
  localparam int unsigned HOLD_DEPTH = 16;
  localparam int unsigned CNT_W = 12;
  // mode detector codes
  typedef enum logic [1:0] {
    PROTO_A    = 2'b00,
    PROTO_B    = 2'b01,
    PROTO_F    = 2'b10,
    PROTO_NONE = 2'b11
  } rcc_proto_t;
  // status bits
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_ERR  = 1;
  localparam int unsigned ST_MODE = 2;
  localparam int unsigned ST_W    = 3;
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_RECV  = 2'b01,
    S_FLUSH = 2'b10
  } rcc_state_t;
endpackage : rcc_pkg

// ===== hw/rcc_crc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rcc_crc_if;
  logic        load;
  logic        shift;
  logic        din;
  logic        narrow;
  logic [15:0] preset;
  logic [15:0] crc;
  modport eng (input load, input shift, input din, input narrow, input preset, output crc);
  modport ctl (output load, output shift, output din, output narrow, output preset, input crc);
endinterface : rcc_crc_if
`default_nettype wire

// ===== hw/rcc_crc_engine.sv
`timescale 1ns/10ps
`default_nettype none
module rcc_crc_engine (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control and result
  rcc_crc_if.eng   c
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  wire  [15:0] poly = c.narrow ? rcc_pkg::POLY5 : rcc_pkg::POLY16;
  wire  [15:0] mask = c.narrow ? rcc_pkg::MASK5 : rcc_pkg::MASK16;
  wire  [15:0] fb   = (crc_reg[0] ^ c.din) ? poly : '0;

  always_comb begin
    crc_next = crc_reg;
    if (c.load) begin
      crc_next = c.preset & mask;
    end else if (c.shift) begin
      crc_next = ((crc_reg >> 1) & mask) ^ fb;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) crc_reg <= '0;
    else crc_reg <= crc_next;
  end

  assign c.crc = crc_reg;
endmodule : rcc_crc_engine
`default_nettype wire

// ===== hw/rcc_hold_line.sv
`timescale 1ns/10ps
`default_nettype none
module rcc_hold_line (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // control
  input  wire logic       clear,
  input  wire logic       bypass,
  input  wire logic [4:0] len,
  input  wire logic       push,
  input  wire logic       din,
  input  wire logic       pop,
  // output side
  output logic            emit_valid,
  output logic            emit_bit,
  output logic [4:0]      count
);
  localparam int D = rcc_pkg::HOLD_DEPTH;
  logic [D-1:0] hold_reg;
  logic [D-1:0] hold_next;
  logic [4:0]   cnt_reg;
  logic [4:0]   cnt_next;
  wire          full = cnt_reg == len;
  wire          drain = pop && cnt_reg != '0;

  // the last len bits stay back: they may be the crc
  always_comb begin
    hold_next = hold_reg;
    cnt_next  = cnt_reg;
    if (clear) begin
      cnt_next = '0;
    end else if (push && !bypass) begin
      if (full) begin
        for (int i = 0; i < D; i++) begin
          hold_next[i] = (i == int'(len) - 1) ? din : ((i < D - 1) ? hold_reg[i + 1] : 1'b0);
        end
      end else begin
        hold_next[cnt_reg[3:0]] = din;
        cnt_next = cnt_reg + 5'd1;
      end
    end else if (drain && !push) begin
      hold_next = {1'b0, hold_reg[D-1:1]};
      cnt_next  = cnt_reg - 5'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_reg <= '0;
      cnt_reg  <= '0;
    end else begin
      hold_reg <= hold_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign emit_valid = clear ? 1'b0 : (push ? (bypass || full) : drain);
  assign emit_bit   = (push && bypass) ? din : hold_reg[0];
  assign count      = cnt_reg;
endmodule : rcc_hold_line
`default_nettype wire

// ===== hw/rcc_rx_crc_checker.sv
// Behaviour
// - selector 111b seeds crc with free value
// - force-write keeps crc bits in ram
// - short frames pass unchanged when enabled
// - selector picks preset from fixed table
// - 5-bit crc uses preset low byte
// - mode detector writes preset selector
// - type bit zero selects 16-bit crc
// - residue 0000h plain or F0B8h inverted
// - mode detector clears or sets inversion
// - check only when enabled; detector sets it for type B and F, not A
`timescale 1ns/10ps
`default_nettype none
module rcc_rx_crc_checker (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [9:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // mode detector
  input  wire logic        mode_det_valid,
  input  wire logic [1:0]  mode_det_proto,
  // bit decoder stream
  input  wire logic        rx_sof,
  input  wire logic        rx_bit_valid,
  input  wire logic        rx_bit,
  input  wire logic        rx_eof,
  output logic             rx_ready,
  // system ram writer
  output logic             ram_valid,
  output logic             ram_bit,
  output logic             ram_frame_end,
  // result and interrupt
  output logic             crc_fail,
  output logic             irq
);
  localparam int CW = rcc_pkg::CNT_W;
  localparam int SW = rcc_pkg::ST_W;

  logic [31:0]         cfg_reg;
  logic [31:0]         cfg_next;
  logic [SW-1:0]       stat_reg;
  logic [SW-1:0]       stat_next;
  logic [SW-1:0]       mask_reg;
  logic [SW-1:0]       mask_next;
  logic [CW-1:0]       bcnt_reg;
  logic [CW-1:0]       bcnt_next;
  rcc_pkg::rcc_state_t state_reg;
  rcc_pkg::rcc_state_t state_next;
  logic                fail_reg;
  logic                ready_reg;
  logic                ram_valid_reg;
  logic                ram_bit_reg;
  logic                ram_end_reg;
  logic                irq_reg;
  logic [31:0]         rdata_reg;
  logic                emit_valid;
  logic                emit_bit;
  logic [4:0]          hold_cnt;

  rcc_crc_if crc_bus ();

  // register decode
  wire wr_cfg  = reg_wr && reg_addr == rcc_pkg::ADDR_CFG;
  wire wr_stat = reg_wr && reg_addr == rcc_pkg::ADDR_STAT;
  wire wr_mask = reg_wr && reg_addr == rcc_pkg::ADDR_MASK;
  wire rd_cfg  = reg_addr == rcc_pkg::ADDR_CFG;
  wire rd_stat = reg_addr == rcc_pkg::ADDR_STAT;
  wire rd_mask = reg_addr == rcc_pkg::ADDR_MASK;
  wire rd_info = reg_addr == rcc_pkg::ADDR_INFO;

  // configuration fields
  wire [15:0] cfg_free  = cfg_reg[rcc_pkg::CFG_VAL_LSB +: 16];
  wire [2:0]  cfg_sel   = cfg_reg[rcc_pkg::CFG_SEL_LSB +: 3];
  wire        cfg_force = cfg_reg[rcc_pkg::CFG_FORCE];
  wire        cfg_pass  = cfg_reg[rcc_pkg::CFG_PASS];
  wire        cfg_type  = cfg_reg[rcc_pkg::CFG_TYPE];
  wire        cfg_inv   = cfg_reg[rcc_pkg::CFG_INV];
  wire        cfg_en    = cfg_reg[rcc_pkg::CFG_EN];

  // preset table; reserved code falls back to zero
  wire [15:0] preset_tab =
    (cfg_sel == rcc_pkg::SEL_0000) ? rcc_pkg::PRESET_0000 :
    (cfg_sel == rcc_pkg::SEL_6363) ? rcc_pkg::PRESET_6363 :
    (cfg_sel == rcc_pkg::SEL_A671) ? rcc_pkg::PRESET_A671 :
    (cfg_sel == rcc_pkg::SEL_FFFF) ? rcc_pkg::PRESET_FFFF :
    (cfg_sel == rcc_pkg::SEL_0012) ? rcc_pkg::PRESET_0012 :
    (cfg_sel == rcc_pkg::SEL_E012) ? rcc_pkg::PRESET_E012 :
    (cfg_sel == rcc_pkg::SEL_FREE) ? cfg_free :
    rcc_pkg::PRESET_RFU;
  wire [15:0] preset_eff =
    cfg_type ? (preset_tab & rcc_pkg::PRESET_LSB_MASK) : preset_tab;
  wire [4:0]  crc_len    = cfg_type ? rcc_pkg::LEN5 : rcc_pkg::LEN16;
  wire [15:0] resid_mask = cfg_type ? rcc_pkg::MASK5 : rcc_pkg::MASK16;
  wire [15:0] resid_exp  = cfg_inv ? rcc_pkg::RESID_INV : rcc_pkg::RESID_PLAIN;
  wire        resid_ok   = ((crc_bus.crc ^ resid_exp) & resid_mask) == '0;

  // frame events
  wire in_recv     = state_reg == rcc_pkg::S_RECV;
  wire sof_go      = rx_sof && state_reg == rcc_pkg::S_IDLE;
  wire bit_go      = rx_bit_valid && in_recv;
  wire eof_go      = rx_eof && in_recv;
  wire short_frame = bcnt_reg <= CW'(crc_len);
  wire flush_go    = eof_go && !cfg_force && cfg_pass && short_frame
                     && hold_cnt != '0;
  wire chk_fail    = eof_go && cfg_en && !resid_ok;
  wire pop         = state_reg == rcc_pkg::S_FLUSH;
  wire last_pop    = pop && hold_cnt == rcc_pkg::HOLD_ONE;
  wire frame_end   = (eof_go && !flush_go) || last_pop;
  // held tail is the crc: dropped unless the frame was short and passed
  wire hold_clear  = sof_go || (eof_go && !flush_go);
  wire bcnt_max    = &bcnt_reg;

  wire [SW-1:0] stat_set = {mode_det_valid, chk_fail, eof_go};
  wire [SW-1:0] stat_clr = wr_stat ? reg_wdata[SW-1:0] : '0;
  wire [31:0]   info_word = {4'h0, bcnt_reg, crc_bus.crc};
  wire [31:0]   rd_mux =
    rd_cfg  ? cfg_reg :
    rd_stat ? {{(32-SW){1'b0}}, stat_reg} :
    rd_mask ? {{(32-SW){1'b0}}, mask_reg} :
    rd_info ? info_word : '0;

  // crc engine control
  assign crc_bus.load   = sof_go;
  assign crc_bus.shift  = bit_go;
  assign crc_bus.din    = rx_bit;
  assign crc_bus.narrow = cfg_type;
  assign crc_bus.preset = preset_eff;

  rcc_crc_engine u_engine (
    .clk   (clk),
    .reset (reset),
    .c     (crc_bus)
  );

  rcc_hold_line u_hold (
    .clk        (clk),
    .reset      (reset),
    .clear      (hold_clear),
    .bypass     (cfg_force),
    .len        (crc_len),
    .push       (bit_go),
    .din        (rx_bit),
    .pop        (pop),
    .emit_valid (emit_valid),
    .emit_bit   (emit_bit),
    .count      (hold_cnt)
  );

  // mode detector overrides a software write in the same cycle
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_cfg) begin
      cfg_next = reg_wdata & rcc_pkg::CFG_WMASK;
    end
    if (mode_det_valid) begin
      case (mode_det_proto)
        rcc_pkg::PROTO_A: begin
          cfg_next[rcc_pkg::CFG_SEL_LSB +: 3] = rcc_pkg::SEL_6363;
          cfg_next[rcc_pkg::CFG_INV] = 1'b0;
        end
        rcc_pkg::PROTO_B: begin
          cfg_next[rcc_pkg::CFG_SEL_LSB +: 3] = rcc_pkg::SEL_FFFF;
          cfg_next[rcc_pkg::CFG_INV] = 1'b1;
          cfg_next[rcc_pkg::CFG_EN]  = 1'b1;
        end
        rcc_pkg::PROTO_F: begin
          cfg_next[rcc_pkg::CFG_SEL_LSB +: 3] = rcc_pkg::SEL_0000;
          cfg_next[rcc_pkg::CFG_INV] = 1'b0;
          cfg_next[rcc_pkg::CFG_EN]  = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rcc_pkg::S_IDLE: begin
        if (sof_go) state_next = rcc_pkg::S_RECV;
      end
      rcc_pkg::S_RECV: begin
        if (flush_go) state_next = rcc_pkg::S_FLUSH;
        else if (eof_go) state_next = rcc_pkg::S_IDLE;
      end
      rcc_pkg::S_FLUSH: begin
        if (last_pop) state_next = rcc_pkg::S_IDLE;
      end
      default: state_next = rcc_pkg::S_IDLE;
    endcase
  end

  // set wins over a write-one clear
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;
  assign mask_next = wr_mask ? reg_wdata[SW-1:0] : mask_reg;
  assign bcnt_next = sof_go ? '0 : ((bit_go && !bcnt_max) ? bcnt_reg + 1'b1 : bcnt_reg);

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg   <= rcc_pkg::CFG_RESET;
      stat_reg  <= '0;
      mask_reg  <= '0;
      bcnt_reg  <= '0;
      state_reg <= rcc_pkg::S_IDLE;
      rdata_reg <= '0;
      irq_reg   <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      cfg_reg   <= cfg_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      bcnt_reg  <= bcnt_next;
      state_reg <= state_next;
      rdata_reg <= reg_rd ? rd_mux : '0;
      irq_reg   <= |(stat_next & mask_next);
      ready_reg <= state_next != rcc_pkg::S_FLUSH;
    end
  end

  // ram side and verdict
  always_ff @(posedge clk) begin
    if (reset) begin
      ram_valid_reg <= 1'b0;
      ram_bit_reg   <= 1'b0;
      ram_end_reg   <= 1'b0;
      fail_reg      <= 1'b0;
    end else begin
      ram_valid_reg <= emit_valid;
      ram_bit_reg   <= emit_bit;
      ram_end_reg   <= frame_end;
      if (sof_go) fail_reg <= 1'b0;
      else if (eof_go) fail_reg <= chk_fail;
    end
  end

  assign reg_rdata     = rdata_reg;
  assign rx_ready      = ready_reg;
  assign ram_valid     = ram_valid_reg;
  assign ram_bit       = ram_bit_reg;
  assign ram_frame_end = ram_end_reg;
  assign crc_fail      = fail_reg;
  assign irq           = irq_reg;

  property p_free_preset;
    @(posedge clk) disable iff (reset)
    sof_go && cfg_sel == rcc_pkg::SEL_FREE && !cfg_type |=> crc_bus.crc == $past(cfg_free);
  endproperty
  a_free_preset: assert property (p_free_preset) else $error("free preset not loaded");

  property p_force_write;
    @(posedge clk) disable iff (reset)
    bit_go && cfg_force |=> ram_valid && ram_bit == $past(rx_bit);
  endproperty
  a_force_write: assert property (p_force_write) else $error("crc bit not forwarded");

  property p_short_pass;
    @(posedge clk) disable iff (reset)
    eof_go && cfg_pass && !cfg_force && short_frame && hold_cnt != '0
    |=> state_reg == rcc_pkg::S_FLUSH ##1 ram_valid;
  endproperty
  a_short_pass: assert property (p_short_pass) else $error("short frame not passed");

  property p_table_6363;
    @(posedge clk) disable iff (reset)
    sof_go && cfg_sel == rcc_pkg::SEL_6363 && !cfg_type |=> crc_bus.crc == rcc_pkg::PRESET_6363;
  endproperty
  a_table_6363: assert property (p_table_6363) else $error("table preset wrong");

  property p_lsb_only;
    @(posedge clk) disable iff (reset)
    sof_go && cfg_type |=> crc_bus.crc[15:8] == '0;
  endproperty
  a_lsb_only: assert property (p_lsb_only) else $error("5-bit preset too wide");

  property p_mode_b;
    @(posedge clk) disable iff (reset)
    mode_det_valid && mode_det_proto == rcc_pkg::PROTO_B
    |=> cfg_sel == rcc_pkg::SEL_FFFF && cfg_inv && cfg_en;
  endproperty
  a_mode_b: assert property (p_mode_b) else $error("type b settings not applied");

  property p_mode_a;
    @(posedge clk) disable iff (reset)
    mode_det_valid && mode_det_proto == rcc_pkg::PROTO_A
    |=> cfg_sel == rcc_pkg::SEL_6363 && !cfg_inv;
  endproperty
  a_mode_a: assert property (p_mode_a) else $error("type a settings not applied");

  property p_strip;
    @(posedge clk) disable iff (reset)
    eof_go && !cfg_force && !short_frame |=> state_reg == rcc_pkg::S_IDLE ##1 !ram_valid;
  endproperty
  a_strip: assert property (p_strip) else $error("crc bits leaked to ram");

  property p_residue;
    @(posedge clk) disable iff (reset)
    eof_go && cfg_en |=> crc_fail == !$past(resid_ok);
  endproperty
  a_residue: assert property (p_residue) else $error("residue verdict wrong");

  property p_no_check;
    @(posedge clk) disable iff (reset)
    eof_go && !cfg_en |=> !crc_fail ##1 !stat_reg[rcc_pkg::ST_ERR] || $past(stat_reg[rcc_pkg::ST_ERR], 2);
  endproperty
  a_no_check: assert property (p_no_check) else $error("check ran while disabled");

  property p_err_irq;
    @(posedge clk) disable iff (reset)
    chk_fail && mask_reg[rcc_pkg::ST_ERR] && !wr_mask |=> irq && stat_reg[rcc_pkg::ST_ERR];
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("crc error not raised");

  property p_mode_f;
    @(posedge clk) disable iff (reset)
    mode_det_valid && mode_det_proto == rcc_pkg::PROTO_F
    |=> cfg_sel == rcc_pkg::SEL_0000 && !cfg_inv && cfg_en;
  endproperty
  a_mode_f: assert property (p_mode_f) else $error("212/424 settings not applied");

  // flush owns the ram side, so a new frame has to wait
  property p_ready_flush;
    @(posedge clk) disable iff (reset)
    state_reg == rcc_pkg::S_FLUSH |-> !rx_ready;
  endproperty
  a_ready_flush: assert property (p_ready_flush) else $error("ready high during flush");

  property p_narrow_preset;
    @(posedge clk) disable iff (reset)
    sof_go && cfg_sel == rcc_pkg::SEL_FREE && cfg_type
    |=> crc_bus.crc == ($past(cfg_free) & rcc_pkg::PRESET_LSB_MASK & rcc_pkg::MASK5);
  endproperty
  a_narrow_preset: assert property (p_narrow_preset) else $error("5-bit preset wrong");

  property p_hold_tail;
    @(posedge clk) disable iff (reset)
    bit_go && !cfg_force && !cfg_type && hold_cnt < rcc_pkg::LEN16 |=> !ram_valid;
  endproperty
  a_hold_tail: assert property (p_hold_tail) else $error("16-bit tail not held");
endmodule : rcc_rx_crc_checker
`default_nettype wire

// ===== dv/rcc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module rcc_far_model (
  // clock
  input  wire logic clk,
  // bit decoder side
  output logic      rx_sof,
  output logic      rx_bit_valid,
  output logic      rx_bit,
  output logic      rx_eof,
  input  wire logic rx_ready,
  // ram writer side
  input  wire logic ram_valid,
  input  wire logic ram_bit,
  input  wire logic ram_frame_end
);
  logic ram_q [$];
  int   ends = 0;
  int   busy = 0;

  initial begin
    rx_sof = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    rx_eof = 1'b0;
  end

  always @(posedge clk) begin
    if (ram_valid === 1'b1) ram_q.push_back(ram_bit);
    if (ram_frame_end === 1'b1) ends++;
    if (rx_ready === 1'b0) busy++;
  end

  // data line flips between strobes so a stale bit never looks valid
  task automatic send(input bit b[$], input int gap, output bit ok);
    int n;
    int e0;
    n = 0;
    e0 = ends;
    while (rx_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rx_sof <= 1'b1;
    @(posedge clk);
    rx_sof <= 1'b0;
    foreach (b[i]) begin
      rx_bit_valid <= 1'b1;
      rx_bit <= b[i];
      @(posedge clk);
      if (gap > 0) begin
        rx_bit_valid <= 1'b0;
        rx_bit <= ~b[i];
        repeat (gap) @(posedge clk);
      end
    end
    rx_bit_valid <= 1'b0;
    rx_bit <= ~rx_bit;
    rx_eof <= 1'b1;
    @(posedge clk);
    rx_eof <= 1'b0;
    n = 0;
    // bounded: a lost frame end must not hang the run
    while (ends == e0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    ok = ends != e0;
  endtask : send
endmodule : rcc_far_model
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk;
  logic        reset;
  logic [9:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        mode_det_valid;
  logic [1:0]  mode_det_proto;
  logic        rx_sof, rx_bit_valid, rx_bit, rx_eof, rx_ready;
  logic        ram_valid, ram_bit, ram_frame_end, crc_fail, irq;
  logic [31:0] msk;
  logic [7:0]  mx [4] = '{8'hcc, 8'hdf, 8'hc5, 8'hf6};
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;

  rcc_rx_crc_checker dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_det_valid(mode_det_valid), .mode_det_proto(mode_det_proto),
    .rx_sof(rx_sof), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_eof(rx_eof),
    .rx_ready(rx_ready), .ram_valid(ram_valid), .ram_bit(ram_bit),
    .ram_frame_end(ram_frame_end), .crc_fail(crc_fail), .irq(irq)
  );
  rcc_far_model far (
    .clk(clk), .rx_sof(rx_sof), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_eof(rx_eof), .rx_ready(rx_ready), .ram_valid(ram_valid), .ram_bit(ram_bit),
    .ram_frame_end(ram_frame_end)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data is looked at mid-cycle, the only cycle it stands
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask : rdc

  function automatic int pre(input logic [2:0] s, input int fv);
    case (s)
      3'b001: return 32'h6363;
      3'b010: return 32'ha671;
      3'b011: return 32'hffff;
      3'b100: return 32'h0012;
      3'b101: return 32'he012;
      3'b111: return fv;
      default: return 0;
    endcase
  endfunction : pre

  function automatic int step(input int c, input bit t5, input bit d);
    bit fb;
    fb = c[0] ^ d;
    c = c >> 1;
    if (fb) c = c ^ (t5 ? 32'h14 : 32'h8408);
    return c;
  endfunction : step

  // one frame through the model and the design, then every result compared
  task automatic frame(input int n, input logic [7:0] lo, input bit good);
    bit   b[$];
    logic e[$];
    int   c, r, len, k, fv, bz;
    bit   ok, fl;
    fv = $urandom & 32'hffff;
    len = lo[2] ? 5 : 16;
    c = pre(lo[5:3], fv) & (lo[2] ? 32'h1f : 32'hffff);
    wr(rcc_pkg::ADDR_CFG, {fv[15:0], 8'h00, lo});
    for (k = 0; k < n; k++) b.push_back(1'($urandom));
    r = c;
    foreach (b[i]) r = step(r, lo[2], b[i]);
    for (k = 0; good && k < len; k++) b.push_back(1'((lo[1] ? ~r : r) >> k));
    r = c;
    foreach (b[i]) r = step(r, lo[2], b[i]);
    fl = lo[0] && ((r ^ (lo[1] ? 32'hf0b8 : 32'h0)) & (lo[2] ? 32'h1f : 32'hffff)) != 0;
    k = lo[7] ? b.size() : (b.size() <= len ? (lo[6] ? b.size() : 0) : b.size() - len);
    for (int i = 0; i < k; i++) e.push_back(b[i]);
    bz = far.busy;
    far.send(b, $urandom % 2, ok);
    chk({31'h0, ok}, 32'h1);
    chk(far.busy - bz, (!lo[7] && lo[6] && b.size() <= len) ? b.size() : 0);
    chk(far.ram_q.size(), k);
    for (int i = 0; i < k && i < far.ram_q.size(); i++) chk(far.ram_q[i], e[i]);
    far.ram_q.delete();
    chk({31'h0, crc_fail}, {31'h0, fl});
    rdc(rcc_pkg::ADDR_INFO, {4'h0, 12'(b.size()), 16'(r)});
    rdc(rcc_pkg::ADDR_STAT, {30'h0, fl, 1'b1});
    chk({31'h0, irq}, {31'h0, fl & msk[1]});
    wr(rcc_pkg::ADDR_STAT, 32'h7);
  endtask : frame

  initial begin
    reset = 1'b1;
    reg_addr = 10'h000;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mode_det_valid = 1'b0;
    mode_det_proto = 2'h0;
    msk = 32'h0;
    void'($urandom(14));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdc(rcc_pkg::ADDR_CFG, 32'h0);
    rdc(rcc_pkg::ADDR_INFO, 32'h0);
    wr(rcc_pkg::ADDR_CFG, 32'hffff_ffff);
    rdc(rcc_pkg::ADDR_CFG, 32'hffff_00ff);
    wr(rcc_pkg::ADDR_INFO, 32'hffff_ffff);
    rdc(rcc_pkg::ADDR_INFO, 32'h0);
    wr(10'h3fc, 32'h1234_5678);
    rdc(10'h3fc, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(rcc_pkg::ADDR_CFG, 32'h0000_00f6);
      @(posedge clk);
      mode_det_valid <= 1'b1;
      mode_det_proto <= 2'(p);
      @(posedge clk);
      mode_det_valid <= 1'b0;
      rdc(rcc_pkg::ADDR_CFG, {24'h0, mx[p]});
    end
    chk({31'h0, irq}, 32'h0);
    wr(rcc_pkg::ADDR_MASK, 32'h4);
    rdc(rcc_pkg::ADDR_STAT, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(rcc_pkg::ADDR_STAT, 32'h7);
    rdc(rcc_pkg::ADDR_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    msk = 32'h2;
    wr(rcc_pkg::ADDR_MASK, msk);
    for (int i = 0; i < 8; i++) frame(8 * (1 + i % 3), {2'b00, 3'(i), 1'b0, 1'(i), 1'b1}, i != 5);
    frame(16, 8'h89, 1'b1);
    frame(16, 8'h0b, 1'b0);
    frame(16, 8'h0a, 1'b0);
    frame(12, 8'h3d, 1'b1);
    frame(9, 8'h0d, 1'b0);
    frame(3, 8'h4d, 1'b0);
    frame(16, 8'h49, 1'b0);
    frame(4, 8'h09, 1'b0);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
